// >>> dadm_ctrl_model.sv
/*
 * controller model for the far side of the port: commands, shared bus
 * and write masks, with the bus released (inverted) when not driven.
 * assumes its tasks are called one at a time from just after an edge.
 */
`timescale 1ns/100ps
module dadm_ctrl_model (
    input  wire logic                        mclk,
    output logic [dadm_pkg::CMD_W-1:0]       command_bus,
    output logic [dadm_pkg::BUS_W-1:0]       drv,
    output logic                             drv_on,
    output logic [dadm_pkg::MASK_W-1:0]      write_byte_mask
);
    import dadm_pkg::*;
    // second device select is never driven: nothing relies on it
    initial begin
        command_bus = 4'h0;
        drv = 16'h0000;
        drv_on = 1'b0;
        write_byte_mask = 2'h0;
    end
    task automatic issue(input logic [3:0] cmd, input logic [15:0] a,
                         input logic [3:0] nxt);
        #1;
        command_bus = cmd;
        drv = a;
        drv_on = 1'b1;
        @(posedge mclk) #1;
        command_bus = nxt;
    endtask : issue
    task automatic row(input logic [15:0] a);
        issue(CMD_ROW, a, 4'h0);
        drv = ~drv;
        drv_on = 1'b0;
        @(negedge mclk) #1;
    endtask : row
    // junk stands on the command bus during the data phase
    task automatic rd(input logic [15:0] a, input logic [3:0] junk);
        issue(CMD_READ, a, junk);
        drv = ~drv;
        drv_on = 1'b0;
        @(posedge mclk) #1;
        command_bus = 4'h0;
        @(negedge mclk) #1;
        // turnaround: the port drives the high half until the next rise
        @(posedge mclk) #1;
    endtask : rd
    task automatic wr(input logic [15:0] a, input logic [31:0] d,
                      input logic [1:0] mlo, input logic [1:0] mhi);
        issue(CMD_WRITE, a, 4'h0);
        drv = d[15:0];
        write_byte_mask = mlo;
        @(posedge mclk) #1;
        drv = d[31:16];
        write_byte_mask = mhi;
        @(negedge mclk) #1;
        write_byte_mask = 2'h0;
        drv = ~drv;
        drv_on = 1'b0;
    endtask : wr
endmodule : dadm_ctrl_model

// >>> dadm_pkg.sv
/*
 * shared constants for the address/data/mask port: widths, command codes,
 * state encoding and reset values.
 * assumes nothing of its surroundings; imported by every design file.
 */
package dadm_pkg;
    localparam int BUS_W   = 16;
    localparam int WORD_W  = 32;
    localparam int MASK_W  = 2;
    localparam int CMD_W   = 4;
    localparam int ROW_W   = 4;
    localparam int COL_W   = 4;
    localparam int ADDR_W  = ROW_W + COL_W;
    localparam int STRB_W  = WORD_W / 8;

    // command codes on the command bus (cre, ras_n, cas_n, we_n)
    localparam logic [CMD_W-1:0] CMD_ROW   = 4'h3;
    localparam logic [CMD_W-1:0] CMD_READ  = 4'h5;
    localparam logic [CMD_W-1:0] CMD_WRITE = 4'h4;

    localparam logic [BUS_W-1:0]  BUS_RST  = 16'h0000;
    localparam logic [WORD_W-1:0] WORD_RST = 32'h0000_0000;
    localparam logic [MASK_W-1:0] MASK_RST = 2'h0;
    localparam logic [ROW_W-1:0]  ROW_RST  = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_RST = 8'h00;

    typedef enum logic [2:0] {
        DADM_IDLE = 3'b001,
        DADM_RD   = 3'b010,
        DADM_WR   = 3'b100
    } dadm_state_t;
endpackage : dadm_pkg

// >>> dadm_port.sv
/*
 * device side of a multiplexed address/data port with write byte masking.
 * a one-cycle command phase carries the address; the following cycle is
 * the data phase, moving a 32-bit word as two 16-bit halves on the rising
 * and falling edge of mclk.
 * assumes the controller runs on mclk, drives only legal codes and releases
 * the shared bus while this port drives it; codes on the command bus during
 * a data phase are ignored.
 */
// Operation
// [RULE1] capture address at rising edge in command phase
// [RULE2] data word moves as two halves, both edges
// [RULE3] sample write masks on both clock edges
// [RULE4] masked byte keeps its stored value
// [RULE5] controller raises mask on suppressed byte edges
// [RULE6] controller ignores second device select entirely
// [RULE7] mask bit to byte lane per edge
// [RULE8] controller holds masks low when unused
// [RULE9] command bus captured on rising edge
// [RULE10] device drives shared bus only in read data
`timescale 1ns/100ps
module dadm_port #(
    parameter int ROW_W = dadm_pkg::ROW_W,
    parameter int COL_W = dadm_pkg::COL_W
) (
    input  wire logic                          mclk,
    input  wire logic                          sys_rst,
    input  wire logic [dadm_pkg::CMD_W-1:0]    command_bus,
    input  wire logic [dadm_pkg::BUS_W-1:0]    shared_addr_data_bus_in,
    output logic      [dadm_pkg::BUS_W-1:0]    shared_addr_data_bus_out,
    output logic                               shared_addr_data_bus_oe_n,
    input  wire logic [dadm_pkg::MASK_W-1:0]   write_byte_mask
);
    import dadm_pkg::*;

    localparam int AW = ROW_W + COL_W;

    dadm_state_t       state;
    logic [ROW_W-1:0]  row;
    logic [AW-1:0]     addr;
    logic              rd_drive;
    logic [WORD_W-1:0] rd_word;
    logic              wr_pend;
    logic [BUS_W-1:0]  data_lo;
    logic [MASK_W-1:0] mask_lo;
    logic [BUS_W-1:0]  data_hi;
    logic [MASK_W-1:0] mask_hi;
    logic              wr_commit;
    logic [STRB_W-1:0] wr_strb;
    logic [WORD_W-1:0] rdata;
    logic              cmd_take;

    // commands are taken only between operations
    assign cmd_take = (state == DADM_IDLE);

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            row <= ROW_RST;
        end else if (cmd_take && command_bus == CMD_ROW) begin // [RULE9]
            row <= shared_addr_data_bus_in[ROW_W-1:0]; // [RULE1]
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            addr <= AW'(ADDR_RST);
        end else if (cmd_take && (command_bus == CMD_READ ||
                                  command_bus == CMD_WRITE)) begin
            addr <= {row, shared_addr_data_bus_in[COL_W-1:0]}; // [RULE1]
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state <= DADM_IDLE;
        end else begin
            unique case (state)
                DADM_IDLE: begin
                    if (command_bus == CMD_READ) begin // [RULE9]
                        state <= DADM_RD;
                    end else if (command_bus == CMD_WRITE) begin
                        state <= DADM_WR;
                    end
                end
                DADM_RD: begin
                    state <= DADM_IDLE;
                end
                DADM_WR: begin
                    state <= DADM_IDLE;
                end
                default: begin
                    state <= DADM_IDLE;
                end
            endcase
        end
    end

    // read data phase: the word is fetched at its first rising edge and
    // held until the next, so both halves come from one snapshot
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rd_drive <= 1'b0;
            rd_word  <= WORD_RST;
        end else begin
            rd_drive <= (state == DADM_RD); // [RULE10]
            if (state == DADM_RD) begin
                rd_word <= rdata;
            end
        end
    end

    // rising-edge half of a write: low 16 bits and their masks
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            wr_pend <= 1'b0;
            data_lo <= BUS_RST;
            mask_lo <= MASK_RST;
        end else begin
            wr_pend <= (state == DADM_WR);
            if (state == DADM_WR) begin
                data_lo <= shared_addr_data_bus_in; // [RULE2]
                mask_lo <= write_byte_mask; // [RULE3]
            end
        end
    end

    // falling-edge half of a write; sampled on the same clock's other edge
    always_ff @(negedge mclk) begin
        if (sys_rst) begin
            data_hi <= BUS_RST;
            mask_hi <= MASK_RST;
        end else if (wr_pend) begin
            data_hi <= shared_addr_data_bus_in; // [RULE2]
            mask_hi <= write_byte_mask; // [RULE3]
        end
    end

    // commit at the rising edge that closes the data phase
    assign wr_commit = wr_pend;
    // high mask bit blocks its lane; line 0 -> bytes 0,2, line 1 -> 1,3
    assign wr_strb = ~{mask_hi, mask_lo}; // [RULE4] [RULE7]

    dadm_store #(
        .WORD_W (WORD_W),
        .ADDR_W (AW)
    ) u_store (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .wr_en   (wr_commit),
        .wr_strb (wr_strb),
        .wr_addr (addr),
        .wr_data ({data_hi, data_lo}),
        .rd_addr (addr),
        .rd_data (rdata)
    );

    // ddr output: low half while mclk is high, high half while low; the
    // mux on mclk and the inverter on rd_drive are the only places an output is not a bare flop
    assign shared_addr_data_bus_out = mclk ? rd_word[BUS_W-1:0]
                                           : rd_word[WORD_W-1:BUS_W]; // [RULE2]
    assign shared_addr_data_bus_oe_n = ~rd_drive; // [RULE10]

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    sequence s_read_cmd;
        cmd_take && command_bus == CMD_READ;
    endsequence

    sequence s_read_drive;
        ##2 !shared_addr_data_bus_oe_n ##1 shared_addr_data_bus_oe_n;
    endsequence

    a_row_addr_capture: assert property ( // [RULE1]
        cmd_take && command_bus == CMD_ROW
        |=> row == $past(shared_addr_data_bus_in[ROW_W-1:0]))
        else $error("row address not captured");

    a_col_addr_capture: assert property ( // [RULE9]
        cmd_take && command_bus == CMD_WRITE
        |=> addr == {$past(row), $past(shared_addr_data_bus_in[COL_W-1:0])}
            ##1 wr_pend ##1 !wr_pend)
        else $error("write command not followed by data phase");

    a_read_bus_window: assert property ( // [RULE10]
        s_read_cmd |-> s_read_drive)
        else $error("read data phase drive window wrong");

    a_drive_only_read: assert property ( // [RULE10]
        !shared_addr_data_bus_oe_n |-> $past(state == DADM_RD)
                                       && !wr_pend)
        else $error("bus driven outside read data phase");

    a_read_word_fetch: assert property ( // [RULE2]
        state == DADM_RD |=> rd_word == $past(rdata) && rd_drive)
        else $error("read word not fetched");

    a_mask_lo_lanes: assert property ( // [RULE7]
        state == DADM_WR
        |=> wr_strb[1:0] == ~$past(write_byte_mask) && wr_commit)
        else $error("rising-edge mask not applied");

    a_mask_blocks_byte: assert property ( // [RULE4]
        wr_commit && !wr_strb[0]
        |=> u_store.g_byte[0].lane[$past(addr)] == $past(rdata[7:0]))
        else $error("masked byte was overwritten");

    a_fall_half_sample: assert property ( // [RULE3]
        @(negedge mclk) disable iff (sys_rst)
        wr_pend |=> mask_hi == $past(write_byte_mask)
                    && data_hi == $past(shared_addr_data_bus_in))
        else $error("falling-edge half not sampled");

    a_state_onehot: assert property (
        $onehot(state))
        else $error("state not one-hot");
endmodule : dadm_port

// >>> dadm_port_tb.sv
/*
 * self-checking bench for dadm_port driven by the controller model.
 * assumes one clock; expected words are queued at each read request.
 */
`timescale 1ns/100ps
module dadm_port_tb;
    import dadm_pkg::*;
    logic              mclk = 1'b0;
    logic              sys_rst = 1'b1;
    logic [3:0]        command_bus;
    logic [15:0]       drv, bus_in, dev_out, lo;
    logic              drv_on, oe_n;
    logic [1:0]        write_byte_mask;
    logic [31:0]       mem [256];
    logic [31:0]       notes [$];
    logic [31:0]       r;
    logic [3:0]        row = 4'h0;
    int                num_errors = 0;
    int                comparisons = 0;
    int                seed = 23014;
    always #5 mclk = ~mclk;
    assign bus_in = (oe_n === 1'b0) ? dev_out : drv;
    dadm_port u_dadm_port (.mclk(mclk), .sys_rst(sys_rst),
        .command_bus(command_bus), .shared_addr_data_bus_in(bus_in),
        .shared_addr_data_bus_out(dev_out),
        .shared_addr_data_bus_oe_n(oe_n),
        .write_byte_mask(write_byte_mask));
    dadm_ctrl_model u_dadm_ctrl_model (.mclk(mclk),
        .command_bus(command_bus), .drv(drv), .drv_on(drv_on),
        .write_byte_mask(write_byte_mask));
    task automatic check_val(input logic [31:0] got,
                             input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: %s %h not %h", $time, what, got,
                     exp);
        end
    endtask : check_val
    task automatic print_verdict;
        if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : print_verdict
    // upper bus bits are random: only the low nibble may matter
    task automatic do_rd(input logic [3:0] col, input logic [3:0] junk);
        notes.push_back(mem[{row, col}]);
        u_dadm_ctrl_model.rd({12'($random(seed)), col}, junk);
    endtask : do_rd
    task automatic do_wr(input logic [3:0] col, input logic [31:0] d,
                         input logic [3:0] m);
        for (int b = 0; b < 4; b++) begin
            if (!m[b]) mem[{row, col}][8*b+:8] = d[8*b+:8];
        end
        u_dadm_ctrl_model.wr({12'($random(seed)), col}, d, m[1:0], m[3:2]);
    endtask : do_wr
    always @(posedge mclk) begin
        #2;
        if (oe_n === 1'b0) begin
            lo = dev_out;
            if (drv_on) check_val(32'h1, 32'h0, "bus fight");
            @(negedge mclk) #2;
            if (drv_on) check_val(32'h1, 32'h0, "bus fight");
            if (notes.size() == 0) begin
                check_val(32'h1, 32'h0, "extra read");
            end else begin
                check_val({dev_out, lo}, notes.pop_front(), "word");
            end
        end
    end
    initial begin
        repeat (20000) @(posedge mclk);
        num_errors++;
        print_verdict();
    end
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = 32'h0;
        repeat (4) @(posedge mclk);
        #1;
        check_val({31'h0, oe_n}, 32'h1, "oe_n in reset");
        sys_rst = 1'b0;
        do_rd(4'h0, 4'h0);
        for (int n = 0; n < 80; n++) begin
            r = $random(seed);
            if (r[0]) begin
                row = r[19:16];
                u_dadm_ctrl_model.row(r[31:16]);
            end
            do_wr(r[7:4], $random(seed), r[11:8]);
            // refused codes in the data phase: none may act
            case (r[13:12])
                2'h0: do_rd(r[7:4], CMD_ROW);
                2'h1: do_rd(r[7:4], CMD_READ);
                2'h2: do_rd(r[7:4], CMD_WRITE);
                default: do_rd(r[7:4], 4'h0);
            endcase
            do_rd(r[15:12], 4'h0);
        end
        repeat (3) @(posedge mclk);
        check_val(notes.size(), 32'h0, "reads unanswered");
        print_verdict();
    end
endmodule : dadm_port_tb

// >>> dadm_store.sv
/*
 * word storage of the port: flip-flop array with byte strobes on write
 * and a combinational read by index.
 * assumes one clock and a synchronous active-high reset from the parent.
 */
`timescale 1ns/100ps
module dadm_store #(
    parameter int WORD_W = dadm_pkg::WORD_W,
    parameter int ADDR_W = dadm_pkg::ADDR_W
) (
    input  wire logic                  mclk,
    input  wire logic                  sys_rst,
    input  wire logic                  wr_en,
    input  wire logic [WORD_W/8-1:0]   wr_strb,
    input  wire logic [ADDR_W-1:0]     wr_addr,
    input  wire logic [WORD_W-1:0]     wr_data,
    input  wire logic [ADDR_W-1:0]     rd_addr,
    output logic      [WORD_W-1:0]     rd_data
);
    import dadm_pkg::*;

    localparam int DEPTH = 1 << ADDR_W;

    genvar gb;
    generate
        for (gb = 0; gb < WORD_W / 8; gb++) begin : g_byte
            // one array per lane: a shared word array written from several
            // processes would have more than one driver
            logic [7:0] lane [DEPTH];

            always_ff @(posedge mclk) begin
                if (sys_rst) begin
                    for (int i = 0; i < DEPTH; i++) begin
                        lane[i] <= 8'h00;
                    end
                end else if (wr_en && wr_strb[gb]) begin
                    lane[wr_addr] <= wr_data[gb*8 +: 8];
                end
            end

            assign rd_data[gb*8 +: 8] = lane[rd_addr];
        end
    endgenerate
endmodule : dadm_store
